// File: verilog/ifw_irq_wake.sv
// ifw_irq_wake: interrupt flags, enables, request and sleep wake for the core
// assumes: all inputs synchronous to i_sys_clk; core pulses sleep, retire, return
//
// Overview of operation
// - polarity bit picks rising or falling edge
// - valid external edge sets external flag
// - external enable gates external request
// - flags stay set until software clears
// - external edge wakes only if enabled before
// - vector 0004h after wake only if global
// - timer FFh to 00h sets overflow flag
// - overflow enable gates overflow request
// - enabled port pin change sets change flag
// - port change enable gates change request
// - per-pin enable selects change-detect pins
// - change during port read may be lost
// - comparator change during read may be lost
// - comparator wake needs its and peripheral enable
// - instruction after sleep runs before vector
// - comparator wake enters handler if global set
`timescale 1ns/1ps
module ifw_irq_wake (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  input  wire logic [3:0]               i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic                     i_ext_pin,       // external_interrupt_pin
  input  wire logic [7:0]               i_port_b_pins,
  input  wire logic [7:0]               i_timer_count,   // eight_bit_timer_count
  input  wire logic [ifw_pkg::N_CMP-1:0] i_cmp_out,
  input  wire logic                     i_sleep,         // core executes sleep
  input  wire logic                     i_retire,        // core retired one instruction
  input  wire logic                     i_retfie,        // return from interrupt
  output logic      [7:0]               o_rdata,
  output logic                          o_irq,
  output logic                          o_wake,
  output logic                          o_vector_take,
  output logic      [12:0]              o_vector_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // state carrier
  typedef struct packed {
    logic [7:0]                ctrl;      // interrupt_control_reg
    logic [ifw_pkg::N_CMP-1:0] pflag;     // comparator_irq_flag bits
    logic [ifw_pkg::N_CMP-1:0] pen;       // comparator_irq_enable bits
    logic [7:0]                pinen;     // per_pin_change_enable
    logic [7:0]                opt;       // ext_edge_polarity lives here
    logic                      ext_q;     // last external pin level
    logic [7:0]                port_q;    // last port level
    logic [7:0]                tmr_q;     // last timer count
    logic [ifw_pkg::N_CMP-1:0] cmp_q;     // last comparator outputs
    logic                      ext_armed; // external enable held at sleep entry
    ifw_pkg::ifw_core_e        core;
    logic [7:0]                rdata;
    logic                      irq;
    logic                      wake;
    logic                      vec;
  } ifw_state_s;

  ifw_state_s st;       // registered state
  ifw_state_s next_st;  // next state

  ifw_pkg::ifw_bus_s bus;  // bus request bundle
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // register hit decode, used by writes and the flag check; reads decode by case
  function automatic logic hit(input ifw_pkg::ifw_bus_s b, input logic [3:0] a);
    hit = b.addr == a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  logic       ext_edge;      // qualified external edge
  logic       tmr_wrap;      // timer rolled over
  logic       port_chg;      // enabled port pin changed
  logic [ifw_pkg::N_CMP-1:0] cmp_chg;  // comparator output changed
  logic       periph_req;    // peripheral sources pending and enabled
  logic       req;           // full request
  logic       wake_src;      // source able to wake

  always_comb begin
    // polarity bit high selects rising, low selects falling
    ext_edge = st.opt[ifw_pkg::B_EDGE_POL] ? (i_ext_pin & ~st.ext_q)
                                           : (~i_ext_pin & st.ext_q);
    tmr_wrap = (st.tmr_q == ifw_pkg::TMR_MAX) && (i_timer_count == 8'h00);
    // only selected pins count; a change on the read edge is still caught here,
    // which the looser documented behaviour permits
    port_chg = |((i_port_b_pins ^ st.port_q) & st.pinen);
    cmp_chg  = i_cmp_out ^ st.cmp_q;
    periph_req = st.ctrl[ifw_pkg::B_PERIPH_EN] & |(st.pflag & st.pen);
    wake_src = (st.ctrl[ifw_pkg::B_EXT_FLAG] & st.ext_armed)
             | (st.ctrl[ifw_pkg::B_TMR_FLAG] & st.ctrl[ifw_pkg::B_TMR_EN])
             | (st.ctrl[ifw_pkg::B_PORT_FLAG] & st.ctrl[ifw_pkg::B_PORT_EN])
             | periph_req;
    req = st.ctrl[ifw_pkg::B_GLOBAL_EN] & (
            (st.ctrl[ifw_pkg::B_EXT_FLAG]  & st.ctrl[ifw_pkg::B_EXT_EN])
          | (st.ctrl[ifw_pkg::B_TMR_FLAG]  & st.ctrl[ifw_pkg::B_TMR_EN])
          | (st.ctrl[ifw_pkg::B_PORT_FLAG] & st.ctrl[ifw_pkg::B_PORT_EN])
          | periph_req);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: software writes first, hardware sets win over clears
  always_comb begin
    next_st        = st;
    next_st.ext_q  = i_ext_pin;
    next_st.port_q = i_port_b_pins;
    next_st.tmr_q  = i_timer_count;
    next_st.cmp_q  = i_cmp_out;
    next_st.vec    = 1'b0;
    next_st.rdata  = 8'h00;

    // register writes
    if (bus.wr) begin
      if (hit(bus, ifw_pkg::ADDR_CTRL))  next_st.ctrl  = bus.wdata;
      if (hit(bus, ifw_pkg::ADDR_PFLAG)) next_st.pflag = bus.wdata[ifw_pkg::N_CMP-1:0];
      if (hit(bus, ifw_pkg::ADDR_PEN))   next_st.pen   = bus.wdata[ifw_pkg::N_CMP-1:0];
      if (hit(bus, ifw_pkg::ADDR_PINEN)) next_st.pinen = bus.wdata;
      if (hit(bus, ifw_pkg::ADDR_OPT))   next_st.opt   = bus.wdata;
    end

    // sticky sets, applied after writes so an event is never lost
    if (ext_edge) next_st.ctrl[ifw_pkg::B_EXT_FLAG]  = 1'b1;
    if (tmr_wrap) next_st.ctrl[ifw_pkg::B_TMR_FLAG]  = 1'b1;
    if (port_chg) next_st.ctrl[ifw_pkg::B_PORT_FLAG] = 1'b1;
    next_st.pflag = next_st.pflag | cmp_chg;

    // register reads, data appear the next cycle
    if (bus.rd) begin
      case (bus.addr)
        ifw_pkg::ADDR_CTRL:  next_st.rdata = st.ctrl;
        ifw_pkg::ADDR_PFLAG: next_st.rdata = {6'h00, st.pflag};
        ifw_pkg::ADDR_PEN:   next_st.rdata = {6'h00, st.pen};
        ifw_pkg::ADDR_PINEN: next_st.rdata = st.pinen;
        ifw_pkg::ADDR_OPT:   next_st.rdata = st.opt;
        ifw_pkg::ADDR_CORE:  next_st.rdata = {6'h00, st.core};
        default:             next_st.rdata = 8'h00;  // unmapped reads as zero
      endcase
    end

    // core sequencing
    next_st.wake = 1'b0;
    case (st.core)
      ifw_pkg::ST_RUN: begin
        if (req) begin
          next_st.core = ifw_pkg::ST_VECTOR;
        end else if (i_sleep) begin
          // latch the enable as it stood when sleep began
          next_st.ext_armed = st.ctrl[ifw_pkg::B_EXT_EN];
          next_st.core      = ifw_pkg::ST_SLEEP;
        end
      end
      ifw_pkg::ST_SLEEP: begin
        if (wake_src) begin
          next_st.wake = 1'b1;
          next_st.core = ifw_pkg::ST_POST;
        end
      end
      ifw_pkg::ST_POST: begin
        // instruction after sleep retires, then branch only if global is set
        if (i_retire)
          next_st.core = req ? ifw_pkg::ST_VECTOR : ifw_pkg::ST_RUN;
      end
      ifw_pkg::ST_VECTOR: begin
        next_st.vec = 1'b1;
        next_st.ctrl[ifw_pkg::B_GLOBAL_EN] = 1'b0;
        next_st.core = ifw_pkg::ST_RUN;
      end
      default: next_st.core = ifw_pkg::ST_RUN;
    endcase
    if (st.core != ifw_pkg::ST_SLEEP)
      next_st.ext_armed = next_st.core == ifw_pkg::ST_SLEEP ? next_st.ext_armed : 1'b0;

    // return from interrupt restores the global enable
    if (i_retfie) next_st.ctrl[ifw_pkg::B_GLOBAL_EN] = 1'b1;

    // request output holds off while the core is asleep or being vectored
    next_st.irq = req & (next_st.core == ifw_pkg::ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, reset to constants only
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st       <= '0;
      st.ctrl  <= ifw_pkg::CTRL_RST;
      st.pinen <= ifw_pkg::PINEN_RST;
      st.opt   <= ifw_pkg::OPT_RST;
      st.core  <= ifw_pkg::ST_RUN;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops, except the constant vector address
  assign o_rdata       = st.rdata;
  assign o_irq         = st.irq;
  assign o_wake        = st.wake;
  assign o_vector_take = st.vec;
  assign o_vector_addr = ifw_pkg::IRQ_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_wake;
    st.core == ifw_pkg::ST_SLEEP && wake_src;
  endsequence

  property p_edge_sets;
    @(posedge i_sys_clk) disable iff (i_rst)
      ext_edge |=> st.ctrl[ifw_pkg::B_EXT_FLAG];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_flag_sticky;
    @(posedge i_sys_clk) disable iff (i_rst)
      st.ctrl[ifw_pkg::B_EXT_FLAG] && !(bus.wr && hit(bus, ifw_pkg::ADDR_CTRL))
      |=> st.ctrl[ifw_pkg::B_EXT_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_tmr;
    @(posedge i_sys_clk) disable iff (i_rst)
      tmr_wrap |=> st.ctrl[ifw_pkg::B_TMR_FLAG];
  endproperty
  a_tmr: assert property (p_tmr) else $error("overflow missed");

  property p_port;
    @(posedge i_sys_clk) disable iff (i_rst)
      port_chg |=> st.ctrl[ifw_pkg::B_PORT_FLAG];
  endproperty
  a_port: assert property (p_port) else $error("port change missed");

  property p_no_ext_req;
    @(posedge i_sys_clk) disable iff (i_rst)
      !st.ctrl[ifw_pkg::B_EXT_EN] && !st.ctrl[ifw_pkg::B_TMR_EN]
      && !st.ctrl[ifw_pkg::B_PORT_EN] && !st.ctrl[ifw_pkg::B_PERIPH_EN] |-> !req;
  endproperty
  a_no_ext_req: assert property (p_no_ext_req) else $error("masked request");

  property p_wake;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_wake |=> o_wake ##1 (st.core == ifw_pkg::ST_POST);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not raised");

  property p_post;
    @(posedge i_sys_clk) disable iff (i_rst)
      st.core == ifw_pkg::ST_POST && !i_retire |=> !o_vector_take;
  endproperty
  a_post: assert property (p_post) else $error("vector before in-line step");

  property p_gie_clr;
    @(posedge i_sys_clk) disable iff (i_rst)
      st.core == ifw_pkg::ST_VECTOR && !i_retfie
      |=> o_vector_take && !st.ctrl[ifw_pkg::B_GLOBAL_EN];
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("global not cleared");

  // raw pin levels, so a broken edge decode above cannot hide behind itself
  property p_rise_sets;
    @(posedge i_sys_clk) disable iff (i_rst)
      st.opt[ifw_pkg::B_EDGE_POL] && i_ext_pin && !st.ext_q
      |=> st.ctrl[ifw_pkg::B_EXT_FLAG];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

  property p_fall_sets;
    @(posedge i_sys_clk) disable iff (i_rst)
      !st.opt[ifw_pkg::B_EDGE_POL] && !i_ext_pin && st.ext_q
      |=> st.ctrl[ifw_pkg::B_EXT_FLAG];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge missed");

  // a change on comparator 0 is always caught, the looser lost-on-read case is not used
  property p_cmp_sets;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_cmp_out[0] != st.cmp_q[0]) |=> st.pflag[0];
  endproperty
  a_cmp_sets: assert property (p_cmp_sets) else $error("comparator change missed");

  // nothing armed and no enabled source: the core must stay asleep
  property p_quiet_sleep;
    @(posedge i_sys_clk) disable iff (i_rst)
      st.core == ifw_pkg::ST_SLEEP && !st.ext_armed && !st.ctrl[ifw_pkg::B_TMR_EN]
      && !st.ctrl[ifw_pkg::B_PORT_EN] && !st.ctrl[ifw_pkg::B_PERIPH_EN] |=> !o_wake;
  endproperty
  a_quiet_sleep: assert property (p_quiet_sleep) else $error("wake while unarmed");

  // with the global enable clear the core carries on in line after wake
  property p_inline;
    @(posedge i_sys_clk) disable iff (i_rst)
      st.core == ifw_pkg::ST_POST && i_retire && !st.ctrl[ifw_pkg::B_GLOBAL_EN]
      |=> st.core == ifw_pkg::ST_RUN;
  endproperty
  a_inline: assert property (p_inline) else $error("branch without global");

  property p_irq_masked;
    @(posedge i_sys_clk) disable iff (i_rst)
      !st.ctrl[ifw_pkg::B_GLOBAL_EN] |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("request while masked");

  // wake is a single-cycle pulse, the core counts each one as a new wake
  property p_wake_pulse;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_wake |=> !o_wake;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake held too long");

endmodule // ifw_irq_wake

// File: verilog/ifw_pkg.sv
// ifw_pkg: shared constants and carriers for the interrupt flag and wake block
// assumes: one system clock, registers reached over a plain strobe port
package ifw_pkg;

  // register indices (the bus address is the index itself)
  localparam logic [3:0] ADDR_CTRL     = 4'h0;  // interrupt_control_reg
  localparam logic [3:0] ADDR_PFLAG    = 4'h1;  // peripheral_flag_reg_two
  localparam logic [3:0] ADDR_PEN      = 4'h2;  // peripheral_enable_reg_two
  localparam logic [3:0] ADDR_PINEN    = 4'h3;  // per_pin_change_enable
  localparam logic [3:0] ADDR_OPT      = 4'h4;  // option: edge polarity
  localparam logic [3:0] ADDR_CORE     = 4'h5;  // core status: sleep, vector

  // interrupt_control_reg bit positions
  localparam int B_PORT_FLAG  = 0;
  localparam int B_EXT_FLAG   = 1;
  localparam int B_TMR_FLAG   = 2;
  localparam int B_PORT_EN    = 3;
  localparam int B_EXT_EN     = 4;
  localparam int B_TMR_EN     = 5;
  localparam int B_PERIPH_EN  = 6;
  localparam int B_GLOBAL_EN  = 7;

  // comparator count and option bit
  localparam int N_CMP        = 2;
  localparam int B_EDGE_POL   = 0;

  // reset values, timer top count and interrupt vector address
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] PINEN_RST  = 8'h00;
  localparam logic [7:0] OPT_RST    = 8'h01;  // rising edge after reset
  localparam logic [7:0] TMR_MAX    = 8'hff;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // register bus request carrier
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ifw_bus_s;

  // core sequencing state
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_POST   = 2'b10,   // one in-line instruction after wake
    ST_VECTOR = 2'b11
  } ifw_core_e;

endpackage

// File: tb/ifw_core_model.sv
// ifw_core_model: behavioural core that sleeps, wakes, retires and takes the vector
// assumes: wake and vector pulses from the block last one cycle of i_sys_clk
`timescale 1ns/1ps
module ifw_core_model (
  input  wire logic i_sys_clk,
  input  wire logic i_wake,
  input  wire logic i_vector_take,
  output logic      o_sleep,
  output logic      o_retire,
  output logic      o_retfie
);
  int   n_wake  = 0;    // wake pulses seen
  int   n_vec   = 0;    // vector branches taken
  int   n_early = 0;    // branches before the post-wake instruction retired
  int   lat     = 1;    // cycles to retire the post-wake instruction, bench may slow it
  logic pend    = 1'b0; // woken, post-wake instruction still in flight
  initial begin
    o_sleep  = 1'b0;
    o_retire = 1'b0;
    o_retfie = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // count branches; a branch while the post-wake instruction is pending is early
  always @(posedge i_sys_clk) begin
    if (i_vector_take) begin
      n_vec++;
      if (pend) n_early++;
    end
  end
  // after a wake run exactly one instruction in line before any branch
  always @(posedge i_sys_clk) begin
    if (i_wake) begin
      n_wake++;
      pend = 1'b1;
      repeat (lat) @(posedge i_sys_clk);
      o_retire <= 1'b1;
      @(posedge i_sys_clk);
      o_retire <= 1'b0;
      pend = 1'b0;
    end
  end
  // one-cycle sleep instruction
  task automatic do_sleep();
    @(posedge i_sys_clk);
    o_sleep <= 1'b1;
    @(posedge i_sys_clk);
    o_sleep <= 1'b0;
  endtask
  // one-cycle return from interrupt
  task automatic do_retfie();
    @(posedge i_sys_clk);
    o_retfie <= 1'b1;
    @(posedge i_sys_clk);
    o_retfie <= 1'b0;
  endtask
endmodule // ifw_core_model

// File: tb/ifw_irq_wake_tb.sv
// ifw_irq_wake_tb: register-level tests of flags, enables, request and wake
// assumes: core model drives sleep, retire and return; bench drives bus and pins
`timescale 1ns/1ps
module ifw_irq_wake_tb;
  logic                       i_sys_clk = 1'b0;
  logic                       i_rst     = 1'b1;
  ifw_pkg::ifw_bus_s          bus       = '0;    // register bus carrier
  logic                       i_ext_pin = 1'b0;
  logic [7:0]                 port      = 8'h00; // port levels
  logic [7:0]                 tmr       = 8'h00; // timer count
  logic [ifw_pkg::N_CMP-1:0]  cmp       = '0;    // comparator outputs
  logic                       slp;
  logic                       ret;
  logic                       rfi;
  logic [7:0]                 o_rdata;
  logic                       o_irq;
  logic                       o_wake;
  logic                       o_vt;
  logic [12:0]                o_va;
  int                         failures   = 0;
  int                         n_compared = 0;
  int                         n_irq      = 0;    // request pulses seen
  always #4 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  ifw_irq_wake i_ifw_irq_wake (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(bus.addr),
    .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .i_ext_pin(i_ext_pin),
    .i_port_b_pins(port), .i_timer_count(tmr), .i_cmp_out(cmp), .i_sleep(slp),
    .i_retire(ret), .i_retfie(rfi), .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake),
    .o_vector_take(o_vt), .o_vector_addr(o_va));
  ifw_core_model i_ifw_core_model (.i_sys_clk(i_sys_clk), .i_wake(o_wake),
    .i_vector_take(o_vt), .o_sleep(slp), .o_retire(ret), .o_retfie(rfi));
  // count request cycles; each taken branch should see exactly one
  always @(posedge i_sys_clk) begin
    if (o_irq === 1'b1) n_irq++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare one value, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask
  // one-cycle read strobe, data looked at only in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_rdata, exp);
  endtask
  // change one event source, then leave room for flag, request and branch
  task automatic drv(input int sel, input logic [7:0] v);
    @(posedge i_sys_clk);
    case (sel)
      0: i_ext_pin <= v[0];
      1: port <= v;
      2: tmr <= v;
      default: cmp <= v[ifw_pkg::N_CMP-1:0];
    endcase
    repeat (8) @(posedge i_sys_clk);
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    failures++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h01);
    rd(4'h3, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h00);
    chk(o_va, 13'h0004);
    chk(o_irq, 1'b0);
    $display("test reset done");
    drv(0, 8'h01);
    rd(4'h0, 8'h02);
    repeat (20) @(posedge i_sys_clk);
    rd(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    drv(0, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h4, 8'h00);
    drv(0, 8'h01);
    rd(4'h0, 8'h00);
    drv(0, 8'h00);
    rd(4'h0, 8'h02);
    $display("test edge done");
    wr(4'h0, 8'h10);
    drv(0, 8'h01);
    drv(0, 8'h00);
    rd(4'h0, 8'h12);
    chk(i_ifw_core_model.n_vec, 0);
    wr(4'h0, 8'h92);
    repeat (2) @(posedge i_sys_clk);  // the branch clears the global enable first
    rd(4'h0, 8'h12);
    chk(i_ifw_core_model.n_vec, 1);
    chk(n_irq, 1);
    wr(4'h0, 8'h10);
    i_ifw_core_model.do_retfie();
    rd(4'h0, 8'h90);
    drv(0, 8'h01);
    drv(0, 8'h00);
    chk(i_ifw_core_model.n_vec, 2);
    wr(4'h0, 8'h80);
    drv(0, 8'h01);
    drv(0, 8'h00);
    rd(4'h0, 8'h82);
    chk(i_ifw_core_model.n_vec, 2);
    chk(n_irq, 2);
    $display("test request done");
    wr(4'h0, 8'h00);
    drv(2, 8'hfe);
    drv(2, 8'hff);
    rd(4'h0, 8'h00);
    drv(2, 8'h00);
    rd(4'h0, 8'h04);
    wr(4'h0, 8'h84);
    repeat (2) @(posedge i_sys_clk);  // a masked overflow must not branch
    rd(4'h0, 8'h84);
    chk(i_ifw_core_model.n_vec, 2);
    wr(4'h0, 8'ha4);
    repeat (2) @(posedge i_sys_clk);  // the branch clears the global enable first
    rd(4'h0, 8'h24);
    chk(i_ifw_core_model.n_vec, 3);
    $display("test timer done");
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h10);
    drv(1, 8'h02);
    rd(4'h0, 8'h00);
    drv(1, 8'h12);
    rd(4'h0, 8'h01);
    wr(4'h0, 8'h88);
    drv(1, 8'h02);
    rd(4'h0, 8'h09);
    chk(i_ifw_core_model.n_vec, 4);
    chk(n_irq, 4);
    $display("test port done");
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h10);
    i_ifw_core_model.do_sleep();
    rd(4'h5, 8'h01);
    drv(0, 8'h01);
    chk(i_ifw_core_model.n_wake, 1);
    rd(4'h5, 8'h00);
    chk(i_ifw_core_model.n_vec, 4);
    wr(4'h0, 8'h00);
    i_ifw_core_model.do_sleep();
    wr(4'h0, 8'h10);
    drv(0, 8'h00);
    drv(0, 8'h01);
    rd(4'h5, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h01);
    drv(3, 8'h01);
    rd(4'h5, 8'h01);
    wr(4'h0, 8'h50);
    repeat (8) @(posedge i_sys_clk);
    chk(i_ifw_core_model.n_wake, 2);
    rd(4'h5, 8'h00);
    $display("test ext wake done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'hd0);
    i_ifw_core_model.lat = 4;  // slow core
    i_ifw_core_model.do_sleep();
    drv(3, 8'h00);
    repeat (8) @(posedge i_sys_clk);
    chk(i_ifw_core_model.n_wake, 3);
    chk(i_ifw_core_model.n_vec, 5);
    chk(i_ifw_core_model.n_early, 0);
    chk(n_irq, 5);
    rd(4'h1, 8'h01);
    rd(4'h0, 8'h50);
    $display("test comparator wake done");
    report_and_stop();
  end
endmodule // ifw_irq_wake_tb
